// >>> core/ftx_fee_counter.sv
`timescale 1ns/100ps
`default_nettype none
module ftx_fee_counter #(
  parameter int W = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [1:0] mode_in,
  input wire logic [1:0] syms_sel_in,
  input wire logic up_in,
  input wire logic dn_in,
  input wire logic sym_in,
  output logic [W-1:0] count_out,
  output logic busy_out,
  output logic done_out
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic [6:0] syms;
  logic [6:0] next_syms;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;
  logic [6:0] target;

  always_comb begin
    target = 7'(ftx_pkg::SYMS_BASE << syms_sel_in);
    next_count = count;
    next_syms = syms;
    next_busy = busy;
    next_done = 1'b0;
    if (start_in && mode_in != ftx_pkg::FEE_OFF) begin
      next_count = '0;
      next_syms = '0;
      next_busy = 1'b1;
    end else if (busy) begin
      // Plain modular arithmetic gives the wrap past the signed limits
      if (up_in && mode_in[0] && !(dn_in && mode_in[1])) begin
        next_count = count + W'(1); // R12 R10
      end else if (dn_in && mode_in[1] && !(up_in && mode_in[0])) begin
        next_count = mode_in[0] ? count - W'(1) : count + W'(1); // R12 R10
      end
      if (sym_in) begin
        next_syms = syms + 7'h01;
        if (next_syms == target) begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
      syms <= 7'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      syms <= next_syms;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign count_out = count;
  assign busy_out = busy;
  assign done_out = done;
endmodule
`default_nettype wire

// >>> core/ftx_pkg.sv
package ftx_pkg;
  // Register byte addresses (printed indices are not all multiples of four)
  localparam logic [6:0] IDX_TX_MAIN = 7'h00;
  localparam logic [6:0] IDX_RX_AUX = 7'h01;
  localparam logic [6:0] IDX_FEE_CTRL = 7'h15;
  localparam logic [6:0] IDX_FEE_RESULT = 7'h16;
  localparam logic [6:0] IDX_DIV_ZERO = 7'h20;
  localparam logic [6:0] IDX_DIV_ONE = 7'h21;
  localparam logic [6:0] IDX_TRIM = 7'h22;
  localparam logic [6:0] IDX_STATUS = 7'h23;
  localparam logic [11:0] ADDR_TX_MAIN = {3'h0, IDX_TX_MAIN, 2'h0};
  localparam logic [11:0] ADDR_RX_AUX = {3'h0, IDX_RX_AUX, 2'h0};
  localparam logic [11:0] ADDR_FEE_CTRL = {3'h0, IDX_FEE_CTRL, 2'h0};
  localparam logic [11:0] ADDR_FEE_RESULT = {3'h0, IDX_FEE_RESULT, 2'h0};
  localparam logic [11:0] ADDR_DIV_ZERO = {3'h0, IDX_DIV_ZERO, 2'h0};
  localparam logic [11:0] ADDR_DIV_ONE = {3'h0, IDX_DIV_ONE, 2'h0};
  localparam logic [11:0] ADDR_TRIM = {3'h0, IDX_TRIM, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {3'h0, IDX_STATUS, 2'h0};
  // Field positions in transmit_main_control
  localparam int POS_LOW_NOISE_AMP_BYPASS = 7;
  localparam int POS_PWR_HI = 6;
  localparam int POS_PWR_LO = 4;
  localparam int POS_SYNC = 3;
  localparam int POS_MODE_HI = 2;
  localparam int POS_MODE_LO = 1;
  // Reset values
  localparam logic [7:0] RST_TX_MAIN = 8'h01;
  localparam logic [7:0] RST_RX_AUX = 8'h80;
  localparam logic [7:0] RST_FEE_CTRL = 8'h00;
  localparam logic [23:0] RST_DIV = 24'h000000;
  localparam logic [7:0] RST_TRIM = 8'h00;
  // Fixed bits of the two control registers
  localparam logic [7:0] FIX_MASK_TX = 8'h01;
  localparam logic [7:0] FIX_MASK_RX = 8'hf0;
  // Operating modes on op_mode_hi/op_mode_lo
  localparam logic [1:0] MODE_RX = 2'h1;
  localparam logic [1:0] MODE_TX = 2'h2;
  // Error estimator modes
  localparam logic [1:0] FEE_OFF = 2'h0;
  localparam logic [1:0] FEE_UP = 2'h1;
  localparam logic [1:0] FEE_DN = 2'h2;
  localparam logic [1:0] FEE_BOTH = 2'h3;
  localparam int SYMS_BASE = 8;
endpackage

// >>> core/ftx_top.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: Three-bit power field, seven active levels
// R2: Power field zero turns amplifier off
// R3: Nonzero keeps amplifier on; one is highest
// R4: Bypass routes around amplifier, field still scales
// R5: Transmit loads divider set by data bit
// R6: Data pin input in transmit, output receive
// R7: Host drives bit stream while transmitting
// R8: Host counts up and down over 8
// R9: Host lowers trim on positive error
// R10: Error count signed eight bits, wraps
// R11: Host keeps expected count within range
// R12: Up pulse increments, down pulse decrements; in FEE_DN mode the code increments on a down pulse
// R13: Error result readable at its register
module ftx_top #(
  parameter int DIV_W = 24
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_out,
  input wire logic rx_data_in,
  input wire logic demod_up_in,
  input wire logic demod_dn_in,
  input wire logic demod_sym_in,
  output logic pa_enable_out,
  output logic amplifier_bypass_out,
  output logic [2:0] power_step_out,
  output logic low_noise_amp_bypass_out,
  output logic [DIV_W-1:0] synth_div_out,
  output logic [7:0] oscillator_trim_out,
  output logic [1:0] op_mode_out
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] tx_main;
  logic [7:0] next_tx_main;
  logic [7:0] rx_aux;
  logic [7:0] next_rx_aux;
  logic [7:0] fee_ctrl;
  logic [7:0] next_fee_ctrl;
  logic [DIV_W-1:0] div_zero;
  logic [DIV_W-1:0] next_div_zero;
  logic [DIV_W-1:0] div_one;
  logic [DIV_W-1:0] next_div_one;
  logic [7:0] trim;
  logic [7:0] next_trim;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic fee_start;
  logic next_fee_start;
  logic [DIV_W-1:0] synth_div;
  logic [DIV_W-1:0] next_synth_div;
  logic pin_oe;
  logic next_pin_oe;
  logic pin_out;
  logic next_pin_out;

  // ----------------------------------------------------------------
  // Pin and demodulator synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] next_sync1;
  logic up_prev;
  logic dn_prev;
  logic sym_prev;
  logic tx_bit;
  logic up_pulse;
  logic dn_pulse;
  logic sym_pulse;

  always_comb begin
    next_sync1 = {demod_sym_in, demod_dn_in, demod_up_in, serial_data_pin_in};
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      up_prev <= 1'b0;
      dn_prev <= 1'b0;
      sym_prev <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= sync1;
      up_prev <= sync2[1];
      dn_prev <= sync2[2];
      sym_prev <= sync2[3];
    end
  end

  assign tx_bit = sync2[0]; // R7
  // Edge history resets low, the demodulator's rest level, so no false pulse
  assign up_pulse = sync2[1] & ~up_prev;
  assign dn_pulse = sync2[2] & ~dn_prev;
  assign sym_pulse = sync2[3] & ~sym_prev;

  // ----------------------------------------------------------------
  // Frequency error estimator
  // ----------------------------------------------------------------
  logic [7:0] fee_count;
  logic fee_busy;
  logic fee_done;

  ftx_fee_counter #(
    .W(8)
  ) u_fee (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .start_in(fee_start),
    .mode_in(fee_ctrl[1:0]),
    .syms_sel_in(fee_ctrl[3:2]),
    .up_in(up_pulse),
    .dn_in(dn_pulse),
    .sym_in(sym_pulse),
    .count_out(fee_count),
    .busy_out(fee_busy),
    .done_out(fee_done)
  );

  logic fee_ready;
  logic next_fee_ready;

  // ----------------------------------------------------------------
  // APB slave: zero wait states
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic [1:0] mode;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign mode = {tx_main[ftx_pkg::POS_MODE_HI], tx_main[ftx_pkg::POS_MODE_LO]};

  always_comb begin
    next_tx_main = tx_main;
    next_rx_aux = rx_aux;
    next_fee_ctrl = fee_ctrl;
    next_div_zero = div_zero;
    next_div_one = div_one;
    next_trim = trim;
    if (wr_en) begin
      case (paddr)
        ftx_pkg::ADDR_TX_MAIN: begin
          next_tx_main = pwdata[7:0] | ftx_pkg::FIX_MASK_TX; // R1
        end
        ftx_pkg::ADDR_RX_AUX: begin
          next_rx_aux = (pwdata[7:0] & 8'h0f) | ftx_pkg::RST_RX_AUX;
        end
        ftx_pkg::ADDR_FEE_CTRL: begin
          // Writing any mode but FEE_OFF restarts the measurement
          next_fee_ctrl = {4'h0, pwdata[3:0]};
        end
        ftx_pkg::ADDR_DIV_ZERO: begin
          next_div_zero = pwdata[DIV_W-1:0];
        end
        ftx_pkg::ADDR_DIV_ONE: begin
          next_div_one = pwdata[DIV_W-1:0];
        end
        ftx_pkg::ADDR_TRIM: begin
          next_trim = pwdata[7:0]; // R9
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_main <= ftx_pkg::RST_TX_MAIN;
      rx_aux <= ftx_pkg::RST_RX_AUX;
      fee_ctrl <= ftx_pkg::RST_FEE_CTRL;
      div_zero <= DIV_W'(ftx_pkg::RST_DIV);
      div_one <= DIV_W'(ftx_pkg::RST_DIV);
      trim <= ftx_pkg::RST_TRIM;
    end else begin
      tx_main <= next_tx_main;
      rx_aux <= next_rx_aux;
      fee_ctrl <= next_fee_ctrl;
      div_zero <= next_div_zero;
      div_one <= next_div_one;
      trim <= next_trim;
    end
  end

  // ----------------------------------------------------------------
  // Measurement start and ready flag
  // ----------------------------------------------------------------
  logic ctrl_wr;

  assign ctrl_wr = wr_en & (paddr == ftx_pkg::ADDR_FEE_CTRL);

  always_comb begin
    next_fee_start = ctrl_wr;
    next_fee_ready = fee_ready;
    if (ctrl_wr) begin
      next_fee_ready = 1'b0;
    end
    // Done sets; a clear in the same cycle loses
    if (fee_done) begin
      next_fee_ready = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fee_start <= 1'b0;
      fee_ready <= 1'b0;
    end else begin
      fee_start <= next_fee_start;
      fee_ready <= next_fee_ready;
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = rdata;
    if (rd_en) begin
      case (paddr)
        ftx_pkg::ADDR_TX_MAIN: next_rdata = {24'h000000, tx_main};
        ftx_pkg::ADDR_RX_AUX: next_rdata = {24'h000000, rx_aux};
        ftx_pkg::ADDR_FEE_CTRL: next_rdata = {24'h000000, fee_ctrl};
        ftx_pkg::ADDR_FEE_RESULT: next_rdata = {24'h000000, fee_count}; // R13
        ftx_pkg::ADDR_DIV_ZERO: next_rdata = 32'(div_zero);
        ftx_pkg::ADDR_DIV_ONE: next_rdata = 32'(div_one);
        ftx_pkg::ADDR_TRIM: next_rdata = {24'h000000, trim};
        ftx_pkg::ADDR_STATUS: next_rdata = {29'h00000000, tx_bit, fee_ready, fee_busy};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // Registered so prdata stays put through the access phase
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Modulation and pin direction
  // ----------------------------------------------------------------
  always_comb begin
    // Receive keeps set zero as the local oscillator word
    next_synth_div = div_zero;
    next_pin_oe = 1'b0;
    next_pin_out = 1'b0;
    if (mode == ftx_pkg::MODE_TX) begin
      next_synth_div = tx_bit ? div_one : div_zero; // R5
      next_pin_oe = 1'b0; // R6
    end else if (mode == ftx_pkg::MODE_RX) begin
      next_pin_oe = 1'b1; // R6
      next_pin_out = rx_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      synth_div <= DIV_W'(ftx_pkg::RST_DIV);
      pin_oe <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      synth_div <= next_synth_div;
      pin_oe <= next_pin_oe;
      pin_out <= next_pin_out;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign power_step_out = tx_main[ftx_pkg::POS_PWR_HI:ftx_pkg::POS_PWR_LO]; // R1 R3 R4
  assign pa_enable_out = |tx_main[ftx_pkg::POS_PWR_HI:ftx_pkg::POS_PWR_LO]; // R2 R3
  assign amplifier_bypass_out = rx_aux[3]; // R4
  assign low_noise_amp_bypass_out = tx_main[ftx_pkg::POS_LOW_NOISE_AMP_BYPASS];
  assign synth_div_out = synth_div;
  assign oscillator_trim_out = trim;
  assign op_mode_out = mode;
  assign serial_data_pin_oe_out = pin_oe;
  assign serial_data_pin_out = pin_out;
endmodule
`default_nettype wire

// >>> sim/fsk_tx_control_and_freq_trim_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fsk_tx_control_and_freq_trim_tb;
  logic mclk_in, rst_n_in, psel, penable, pwrite, rx_data_in, drive, tx_bit;
  logic demod_up_in, demod_dn_in, demod_sym_in, serial_data_pin_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, serial_data_pin_out, serial_data_pin_oe_out, pa_enable_out;
  logic amplifier_bypass_out, low_noise_amp_bypass_out;
  logic [2:0] power_step_out;
  logic [23:0] synth_div_out;
  logic [7:0] oscillator_trim_out;
  logic [1:0] op_mode_out;
  int errors, check_count;
  ftx_top i_ftx_top (.mclk_in, .rst_n_in, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .serial_data_pin_in, .serial_data_pin_out,
    .serial_data_pin_oe_out, .rx_data_in, .demod_up_in, .demod_dn_in, .demod_sym_in,
    .pa_enable_out, .amplifier_bypass_out, .power_step_out, .low_noise_amp_bypass_out,
    .synth_div_out, .oscillator_trim_out, .op_mode_out);
  ftx_host_model i_ftx_host_model (.mclk_in(mclk_in), .drive_in(drive), .bit_in(tx_bit),
    .pin_out(serial_data_pin_in));
  // ------------------------------------------------------------
  // Common tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    @(posedge mclk_in);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk_in);
    end
    if (n >= 20) begin
      errors++;
      summarize();
    end
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic pulse(input int which);
    if (which == 0) demod_up_in <= 1'b1;
    else if (which == 1) demod_dn_in <= 1'b1;
    else demod_sym_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    demod_up_in <= 1'b0; demod_dn_in <= 1'b0; demod_sym_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    apb(0, ftx_pkg::ADDR_TX_MAIN, 0); chk("tx_main", 32'h01, q);
    apb(0, ftx_pkg::ADDR_RX_AUX, 0); chk("rx_aux", 32'h80, q);
    apb(0, 12'hffc, 0); chk("unmapped", 32'h0, q);
    chk("pa_en", 0, pa_enable_out);
    $display("t_reset done");
  endtask
  task automatic t_power();
    for (int p = 0; p < 8; p++) begin
      apb(1, ftx_pkg::ADDR_TX_MAIN, {1'b0, p[2:0], 4'h0});
      apb(0, ftx_pkg::ADDR_TX_MAIN, 0); chk("tx_rb", {1'b0, p[2:0], 4'h1}, q);
      chk("step", p, power_step_out);
      chk("pa_en", p != 0, pa_enable_out);
    end
    apb(1, ftx_pkg::ADDR_RX_AUX, 32'h08);
    @(posedge mclk_in);
    chk("bypass", 1, amplifier_bypass_out);
    chk("step_kept", 7, power_step_out);
    apb(1, ftx_pkg::ADDR_TX_MAIN, 32'hf0);
    @(posedge mclk_in);
    chk("low_noise_amp_bypass", 1, low_noise_amp_bypass_out);
    chk("step_lna", 7, power_step_out);
    chk("mode_idle", 0, op_mode_out);
    $display("t_power done");
  endtask
  task automatic t_mod();
    apb(1, ftx_pkg::ADDR_DIV_ZERO, 32'h123456);
    apb(1, ftx_pkg::ADDR_DIV_ONE, 32'habcdef);
    apb(1, ftx_pkg::ADDR_TX_MAIN, {4'h1, 1'b0, ftx_pkg::MODE_TX, 1'b1});
    for (int b = 0; b < 4; b++) begin
      drive <= 1'b1; tx_bit <= b[0];
      repeat (6) @(posedge mclk_in);
      chk("div", b[0] ? 32'habcdef : 32'h123456, synth_div_out);
      chk("oe_tx", 0, serial_data_pin_oe_out);
    end
    drive <= 1'b0;
    apb(1, ftx_pkg::ADDR_TX_MAIN, {4'h1, 1'b0, ftx_pkg::MODE_RX, 1'b1});
    for (int b = 1; b >= 0; b--) begin
      rx_data_in <= b[0];
      repeat (4) @(posedge mclk_in);
      chk("oe_rx", 1, serial_data_pin_oe_out);
      chk("pin_out", b[0], serial_data_pin_out);
    end
    $display("t_mod done");
  endtask
  task automatic run_fee(input logic [1:0] m, input int ups, input int dns,
    input logic [7:0] e);
    int n;
    apb(1, ftx_pkg::ADDR_FEE_CTRL, {30'h0, m});
    for (int s = 0; s < 8; s++) begin
      repeat (ups) pulse(0);
      repeat (dns) pulse(1);
      pulse(2);
    end
    n = 0;
    q = 0;
    while (q[1] !== 1'b1 && n < 40) begin
      apb(0, ftx_pkg::ADDR_STATUS, 0);
      n++;
    end
    if (n >= 40) begin
      errors++;
      summarize();
    end
    apb(0, ftx_pkg::ADDR_FEE_RESULT, 0); chk("fee", e, q);
  endtask
  task automatic t_fee();
    logic [7:0] t;
    run_fee(ftx_pkg::FEE_UP, 2, 1, 8'h10);
    run_fee(ftx_pkg::FEE_DN, 2, 1, 8'h08);
    run_fee(ftx_pkg::FEE_BOTH, 3, 1, 8'h10);
    t = $signed(q[7:0]) > 0 ? 8'h7f : 8'h81;
    apb(1, ftx_pkg::ADDR_TRIM, 32'h80);
    apb(1, ftx_pkg::ADDR_TRIM, {24'h0, t});
    @(posedge mclk_in);
    chk("trim", 8'h7f, oscillator_trim_out);
    run_fee(ftx_pkg::FEE_BOTH, 0, 17, 8'h78);
    $display("t_fee done");
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mclk_in = 0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  initial begin
    errors = 0; check_count = 0; rst_n_in = 0;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; q = 0;
    rx_data_in = 0; drive = 0; tx_bit = 0;
    demod_up_in = 0; demod_dn_in = 0; demod_sym_in = 0;
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_power();
    t_mod();
    t_fee();
    summarize();
  end
  initial begin
    repeat (90000) @(posedge mclk_in);
    errors++;
    summarize();
  end
endmodule
`default_nettype wire

// >>> sim/ftx_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ftx_host_model (
  input wire logic mclk_in,
  input wire logic drive_in,
  input wire logic bit_in,
  output logic pin_out
);
  logic last;
  initial begin
    last = 1'b0;
    pin_out = 1'b1;
  end
  // Released pin shows inverse of last bit, never a stale match
  always @(posedge mclk_in) begin
    if (drive_in) begin
      pin_out <= bit_in;
      last <= bit_in;
    end else begin
      pin_out <= ~last;
    end
  end
endmodule
`default_nettype wire

// >>> sim/ftx_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ftx_top_sva (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_data_pin_oe_out,
  input wire logic pa_enable_out,
  input wire logic amplifier_bypass_out,
  input wire logic [2:0] power_step_out,
  input wire logic [1:0] op_mode_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  property p_pa_off;
    power_step_out == 3'h0 |-> !pa_enable_out;
  endproperty
  a_pa_off: assert property (p_pa_off) else $error("amp on at zero level");
  property p_pa_on;
    power_step_out != 3'h0 |-> pa_enable_out;
  endproperty
  a_pa_on: assert property (p_pa_on) else $error("amp off at active level");
  property p_oe_tx;
    (op_mode_out == ftx_pkg::MODE_TX) && ($past(op_mode_out) == ftx_pkg::MODE_TX)
      |-> !serial_data_pin_oe_out;
  endproperty
  a_oe_tx: assert property (p_oe_tx) else $error("pin driven in transmit");
  property p_oe_rx;
    (op_mode_out == ftx_pkg::MODE_RX) && ($past(op_mode_out) == ftx_pkg::MODE_RX)
      |-> serial_data_pin_oe_out;
  endproperty
  a_oe_rx: assert property (p_oe_rx) else $error("pin not driven in receive");
  property p_step_wr;
    $changed(power_step_out) |-> $past(psel && penable && pwrite);
  endproperty
  a_step_wr: assert property (p_step_wr) else $error("level moved without write");
  property p_mode_wr;
    $changed(op_mode_out) |-> $past(psel && penable && pwrite);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode moved without write");
  property p_bypass;
    $changed(amplifier_bypass_out) |-> $stable(power_step_out);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass disturbed level");
  property p_rd_hold;
    !(psel && !penable) ##1 !(psel && !penable) |-> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_ready;
    psel && penable |-> pready && !pslverr;
  endproperty
  a_ready: assert property (p_ready) else $error("bad bus answer");
endmodule
bind ftx_top ftx_top_sva i_ftx_top_sva (.mclk_in, .rst_n_in, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .serial_data_pin_oe_out, .pa_enable_out,
  .amplifier_bypass_out, .power_step_out, .op_mode_out);
`default_nettype wire
